// *** hdl/cfg_regs_pkg.sv ***
// package: register map, field layout, defaults and timing for the interface configuration bank
package cfg_regs_pkg;

  // ****************************************
  // register addresses
  // ****************************************
  localparam int ADDR_W = 15;
  localparam logic [ADDR_W-1:0] ADDR_INTERFACE_CONFIG_A = 15'h0000;
  localparam logic [ADDR_W-1:0] ADDR_POWER_STATE_CONFIG = 15'h0002;
  localparam logic [ADDR_W-1:0] ADDR_PART_CLASS = 15'h0003;
  localparam logic [ADDR_W-1:0] ADDR_USER_CONFIG = 15'h0010;
  localparam logic [ADDR_W-1:0] ADDR_COEF_B8_LO = 15'h0459;
  localparam logic [ADDR_W-1:0] ADDR_COEF_B8_HI = 15'h045A;

  // ****************************************
  // field positions
  // ****************************************
  localparam int SOFT_RESET_BIT = 7;
  localparam int ASCEND_BIT = 5;
  localparam int SERIAL_OUT_ONLY_BIT = 4;
  localparam int ADDR_HOLD_BIT = 0;
  localparam int READ_FLAG_BIT = 7;

  // ****************************************
  // reset values and fixed codes
  // ****************************************
  localparam logic [7:0] INTERFACE_CONFIG_A_RST = 8'h30;
  localparam logic [7:0] POWER_STATE_CONFIG_RST = 8'h00;
  localparam logic [7:0] USER_CONFIG_RST = 8'h00;
  localparam logic [15:0] COEF_B8_RST = 16'h0000;
  localparam logic [3:0] PART_CLASS_HI_RST = 4'h0;
  localparam logic [1:0] POWER_NORMAL = 2'h0;
  localparam logic [1:0] POWER_DOWN = 2'h3;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;

  // ****************************************
  // soft reset timing
  // ****************************************
  localparam int CLOCK_PERIOD_PS = 4000;
  localparam int SOFT_RESET_TIME_NS = 750;
  localparam int SOFT_RESET_CYCLES = (SOFT_RESET_TIME_NS * 1000 + CLOCK_PERIOD_PS - 1) / CLOCK_PERIOD_PS;
  localparam int HOLD_CNT_W = 9;

endpackage : cfg_regs_pkg

// *** hdl/interface_config_regs.sv ***
// module: serial-programmed interface configuration register bank
`timescale 1ns/10ps
module interface_config_regs
  import cfg_regs_pkg::*;
#(
  parameter int RESET_HOLD_CYCLES = SOFT_RESET_CYCLES,
  parameter logic [3:0] PART_CLASS_CODE = 4'h9 // arbitrary value
) (
  // clock and reset
  input wire logic CLOCK,
  input wire logic SYS_RST,
  // serial port
  input wire logic SCLK,
  input wire logic SCS_N,
  input wire logic SDI,
  output logic SDO,
  // device controls
  output logic CHIP_RESET,
  output logic [1:0] POWER_MODE,
  output logic [15:0] COEF_B8
);

  // ****************************************
  // types and state
  // ****************************************
  typedef enum logic [1:0] {P_INSTR_HI, P_INSTR_LO, P_DATA, P_IGNORE} phase_t;

  typedef struct packed {
    phase_t phase;
    logic rd;
    logic [ADDR_W-1:0] addr;
    logic [7:0] cfg_a;
    logic [7:0] pwr;
    logic [3:0] cls_hi;
    logic [7:0] usr;
    logic [15:0] coef;
    logic [HOLD_CNT_W-1:0] hold_cnt;
    logic busy;
    logic tx_load;
    logic [7:0] tx_byte;
  } bank_t;

  localparam logic [HOLD_CNT_W-1:0] HOLD_LOAD = HOLD_CNT_W'(RESET_HOLD_CYCLES);

  bank_t q, d;
  logic wr_en;
  logic [ADDR_W-1:0] wr_addr;
  logic [7:0] wr_data;
  logic [ADDR_W-1:0] rd_addr;

  serial_byte_if bus ();

  serial_front u_front (
    .clk(CLOCK),
    .rst(SYS_RST),
    .sclk(SCLK),
    .cs_n(SCS_N),
    .sdi(SDI),
    .bus(bus.front)
  );

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [ADDR_W-1:0] next_addr(input logic [ADDR_W-1:0] a, input logic [7:0] cfg,
                                                  input logic [7:0] usr);
    if (usr[ADDR_HOLD_BIT]) begin
      return a;
    end else if (cfg[ASCEND_BIT]) begin
      return a + 15'h0001;
    end else begin
      return a - 15'h0001;
    end
  endfunction : next_addr

  function automatic logic [7:0] read_reg(input logic [ADDR_W-1:0] a, input bank_t s);
    logic [7:0] v;
    v = UNMAPPED_READ;
    unique case (a)
      ADDR_INTERFACE_CONFIG_A: begin
        v = s.cfg_a;
        v[SOFT_RESET_BIT] = 1'b0;
        v[SERIAL_OUT_ONLY_BIT] = 1'b1;
      end
      ADDR_POWER_STATE_CONFIG: v = s.pwr;
      ADDR_PART_CLASS: v = {s.cls_hi, PART_CLASS_CODE};
      ADDR_USER_CONFIG: v = s.usr;
      ADDR_COEF_B8_LO: v = s.coef[7:0];
      ADDR_COEF_B8_HI: v = s.coef[15:8];
      default: v = UNMAPPED_READ;
    endcase
    return v;
  endfunction : read_reg

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    d = q;
    d.tx_load = 1'b0;
    wr_en = 1'b0;
    wr_addr = q.addr;
    wr_data = bus.rx_byte;
    rd_addr = q.addr;
    if (q.hold_cnt != '0) begin
      d.hold_cnt = q.hold_cnt - 9'h001;
    end
    if (!bus.frame_active) begin
      d.phase = P_INSTR_HI;
    end else if (bus.rx_valid) begin
      unique case (q.phase)
        P_INSTR_HI: begin
          d.rd = bus.rx_byte[READ_FLAG_BIT];
          d.addr = {bus.rx_byte[6:0], q.addr[7:0]};
          d.phase = P_INSTR_LO;
        end
        P_INSTR_LO: begin
          d.addr = {q.addr[14:8], bus.rx_byte};
          d.phase = P_DATA;
          rd_addr = {q.addr[14:8], bus.rx_byte};
          if (q.rd) begin
            d.tx_byte = read_reg(rd_addr, q);
            d.tx_load = 1'b1;
            d.addr = next_addr(rd_addr, q.cfg_a, q.usr);
          end
        end
        P_DATA: begin
          d.addr = next_addr(q.addr, q.cfg_a, q.usr);
          if (q.rd) begin
            d.tx_byte = read_reg(q.addr, q);
            d.tx_load = 1'b1;
          end else begin
            wr_en = 1'b1;
          end
        end
        P_IGNORE: d.phase = P_IGNORE;
      endcase
    end
    if (wr_en) begin
      unique case (wr_addr)
        ADDR_INTERFACE_CONFIG_A: begin
          d.cfg_a = wr_data;
          d.cfg_a[SOFT_RESET_BIT] = 1'b0;
          d.cfg_a[SERIAL_OUT_ONLY_BIT] = 1'b1;
        end
        ADDR_POWER_STATE_CONFIG: d.pwr = wr_data;
        ADDR_PART_CLASS: d.cls_hi = wr_data[7:4];
        ADDR_USER_CONFIG: d.usr = wr_data;
        ADDR_COEF_B8_LO: d.coef[7:0] = wr_data;
        ADDR_COEF_B8_HI: d.coef[15:8] = wr_data;
        default: d.cfg_a = d.cfg_a;
      endcase
      if (wr_addr == ADDR_INTERFACE_CONFIG_A && wr_data[SOFT_RESET_BIT]) begin
        // whole bank back to defaults, rest of frame ignored
        d.cfg_a = INTERFACE_CONFIG_A_RST;
        d.pwr = POWER_STATE_CONFIG_RST;
        d.cls_hi = PART_CLASS_HI_RST;
        d.usr = USER_CONFIG_RST;
        d.coef = COEF_B8_RST;
        d.addr = '0;
        d.rd = 1'b0;
        d.phase = P_IGNORE;
        d.hold_cnt = HOLD_LOAD;
      end
    end
    if (q.busy && bus.frame_active) begin
      d.phase = P_IGNORE;
    end
    d.busy = (d.hold_cnt != '0);
  end

  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      q <= '0;
      q.phase <= P_INSTR_HI;
      q.cfg_a <= INTERFACE_CONFIG_A_RST;
      q.pwr <= POWER_STATE_CONFIG_RST;
      q.usr <= USER_CONFIG_RST;
      q.coef <= COEF_B8_RST;
    end else begin
      q <= d;
    end
  end

  assign bus.tx_load = q.tx_load;
  assign bus.tx_byte = q.tx_byte;
  assign SDO = bus.sdo;
  assign CHIP_RESET = q.busy;
  assign POWER_MODE = q.pwr[1:0];
  assign COEF_B8 = q.coef;

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (SYS_RST);

  logic soft_wr;
  assign soft_wr = wr_en && wr_addr == ADDR_INTERFACE_CONFIG_A && wr_data[SOFT_RESET_BIT];

  a_soft_defaults: assert property (soft_wr |=> q.cfg_a == INTERFACE_CONFIG_A_RST && q.pwr == '0 && q.usr == '0)
    else $error("soft reset left a register off its default");
  a_soft_hold: assert property (soft_wr |=> CHIP_RESET [*8])
    else $error("chip reset did not hold after soft reset");
  a_self_clear: assert property (q.tx_load && $past(rd_addr) == ADDR_INTERFACE_CONFIG_A
                                 |-> !q.tx_byte[SOFT_RESET_BIT] && q.tx_byte[SERIAL_OUT_ONLY_BIT])
    else $error("config read shows soft reset set or serial flag clear");
  a_ascend_step: assert property (bus.rx_valid && q.phase == P_DATA && !q.usr[ADDR_HOLD_BIT] && q.cfg_a[ASCEND_BIT]
                                  && !soft_wr |=> q.addr == $past(q.addr) + 15'h0001)
    else $error("address did not increment");
  a_descend_step: assert property (bus.rx_valid && q.phase == P_DATA && !q.usr[ADDR_HOLD_BIT] && !q.cfg_a[ASCEND_BIT]
                                   && !soft_wr |=> q.addr == $past(q.addr) - 15'h0001)
    else $error("address did not decrement");
  a_hold_addr: assert property (bus.rx_valid && q.phase == P_DATA && q.usr[ADDR_HOLD_BIT] && !soft_wr
                                |=> $stable(q.addr))
    else $error("held address moved");
  a_reset_vals: assert property ($fell(SYS_RST) |-> q.cfg_a == INTERFACE_CONFIG_A_RST
                                 && POWER_MODE == POWER_NORMAL)
    else $error("reset values wrong");
  a_power_write: assert property (wr_en && wr_addr == ADDR_POWER_STATE_CONFIG
                                  |=> POWER_MODE == $past(wr_data[1:0]))
    else $error("power mode not taken from write");
  a_class_code: assert property (q.tx_load && $past(rd_addr) == ADDR_PART_CLASS
                                 |-> q.tx_byte[3:0] == PART_CLASS_CODE)
    else $error("part class code changed");
  a_ro_ignore: assert property (wr_en && wr_addr == ADDR_INTERFACE_CONFIG_A |=> q.cfg_a[SERIAL_OUT_ONLY_BIT])
    else $error("read-only flag took a written zero");

  c_soft_reset: cover property (soft_wr ##1 CHIP_RESET);
  c_stream_read: cover property (q.rd && q.tx_load ##[1:200] q.tx_load);
  c_stream_write: cover property (wr_en ##[1:200] wr_en);
  c_power_down: cover property (POWER_MODE == POWER_DOWN);

endmodule : interface_config_regs

// *** hdl/serial_byte_if.sv ***
// interface: byte stream between the serial front end and the register bank
`timescale 1ns/10ps
interface serial_byte_if;
  logic frame_active;
  logic rx_valid;
  logic [7:0] rx_byte;
  logic tx_load;
  logic [7:0] tx_byte;
  logic sdo;

  modport front (output frame_active, output rx_valid, output rx_byte, output sdo, input tx_load, input tx_byte);
  modport bank (input frame_active, input rx_valid, input rx_byte, input sdo, output tx_load, output tx_byte);
endinterface : serial_byte_if

// *** hdl/serial_front.sv ***
// module: serial bit shifter, frames bytes in from the data input and shifts bytes out
`timescale 1ns/10ps
module serial_front
  import cfg_regs_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // serial pins, sampled on the system clock
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic sdi,
  // byte side
  serial_byte_if.front bus
);

  typedef struct packed {
    logic sclk_prev;
    logic active;
    logic [2:0] bit_cnt;
    logic [7:0] rx_sh;
    logic rx_valid;
    logic [7:0] rx_byte;
    logic [7:0] tx_sh;
    logic sdo;
  } front_t;

  front_t q, d;

  always_comb begin
    d = q;
    d.rx_valid = 1'b0;
    d.sclk_prev = sclk;
    d.active = !cs_n;
    if (cs_n) begin
      d.bit_cnt = 3'h0;
      d.sdo = 1'b0;
    end else if (sclk && !q.sclk_prev) begin
      // capture on the rising edge
      d.rx_sh = {q.rx_sh[6:0], sdi};
      d.bit_cnt = q.bit_cnt + 3'h1;
      if (q.bit_cnt == 3'h7) begin
        d.rx_valid = 1'b1;
        d.rx_byte = {q.rx_sh[6:0], sdi};
      end
    end
    // launch on the falling edge, a fresh load takes priority
    if (bus.tx_load) begin
      d.tx_sh = bus.tx_byte;
    end else if (!cs_n && !sclk && q.sclk_prev) begin
      d.sdo = q.tx_sh[7];
      d.tx_sh = {q.tx_sh[6:0], 1'b0};
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign bus.frame_active = q.active;
  assign bus.rx_valid = q.rx_valid;
  assign bus.rx_byte = q.rx_byte;
  assign bus.sdo = q.sdo;

endmodule : serial_front

// *** test/interface_config_regs_tb_top.sv ***
// testbench: register defaults, field access, streaming and soft reset of the config bank
`timescale 1ns/10ps
module interface_config_regs_tb_top;
  import cfg_regs_pkg::*;
  localparam int HOLD = 10;
  localparam logic [3:0] CLASS_CODE = 4'h6; // arbitrary value
  logic CLOCK = 1'b0;
  logic SYS_RST = 1'b1;
  wire logic SCLK;
  wire logic SCS_N;
  wire logic SDI;
  logic SDO;
  logic CHIP_RESET;
  logic [1:0] POWER_MODE;
  logic [15:0] COEF_B8;
  int error_cnt = 0;
  int tests_run = 0;
  int hi_cnt = 0;
  logic [31:0] seed = 32'h3374;
  logic [7:0] v;
  logic [7:0] x;

  always #2 CLOCK = ~CLOCK;
  always @(posedge CLOCK) if (CHIP_RESET === 1'b1) hi_cnt <= hi_cnt + 1;

  interface_config_regs #(.RESET_HOLD_CYCLES(HOLD), .PART_CLASS_CODE(CLASS_CODE)) dut_u (
    .CLOCK(CLOCK), .SYS_RST(SYS_RST), .SCLK(SCLK), .SCS_N(SCS_N), .SDI(SDI), .SDO(SDO),
    .CHIP_RESET(CHIP_RESET), .POWER_MODE(POWER_MODE), .COEF_B8(COEF_B8));
  spi_host_model host_u (.clk(CLOCK), .sclk(SCLK), .scs_n(SCS_N), .sdi(SDI), .sdo(SDO));

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [7:0] next_rand();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed[7:0];
  endfunction : next_rand

  function automatic logic [7:0] cfg_exp(input logic [7:0] w);
    return {1'b0, w[6:5], 1'b1, w[3:0]};
  endfunction : cfg_exp

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      $display("wrong value %s expected %h seen %h", name, exp, seen);
      error_cnt++;
    end
  endtask : check

  task automatic wr1(input logic [14:0] a, input logic [7:0] d);
    host_u.wbuf[0] = d;
    host_u.xfer(1'b0, a, 1);
  endtask : wr1

  task automatic rd1(input logic [14:0] a, output logic [7:0] d);
    host_u.xfer(1'b1, a, 1);
    d = host_u.rbuf[0];
  endtask : rd1

  task automatic complete_run();
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : complete_run

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    repeat (4) @(posedge CLOCK);
    SYS_RST <= 1'b0;
    rd1(ADDR_INTERFACE_CONFIG_A, x);
    check("config a reset", x, 16'h0030);
    rd1(ADDR_POWER_STATE_CONFIG, x);
    check("power reg reset", x, 16'h0000);
    check("power mode reset", POWER_MODE, 16'h0000);
    rd1(ADDR_PART_CLASS, x);
    check("part class", x, {8'h00, 4'h0, CLASS_CODE});
    $display("test defaults done");
    for (int i = 0; i < 4; i++) begin
      v = (i == 0) ? 8'h00 : (next_rand() & 8'h7F);
      wr1(ADDR_INTERFACE_CONFIG_A, v);
      rd1(ADDR_INTERFACE_CONFIG_A, x);
      check("config a", x, cfg_exp(v));
    end
    $display("test config access done");
    for (int m = 0; m < 4; m++) begin
      v = {next_rand() & 8'hFC} | m[7:0];
      wr1(ADDR_POWER_STATE_CONFIG, v);
      check("power mode", POWER_MODE, m[15:0]);
      rd1(ADDR_POWER_STATE_CONFIG, x);
      check("power reg", x, v);
    end
    wr1(ADDR_PART_CLASS, 8'hFF);
    rd1(ADDR_PART_CLASS, x);
    check("part class write", x, {8'h00, 4'hF, CLASS_CODE});
    $display("test power and class done");
    wr1(ADDR_INTERFACE_CONFIG_A, 8'h30);
    host_u.wbuf[0] = 8'h5A;
    host_u.wbuf[1] = next_rand();
    host_u.xfer(1'b0, ADDR_COEF_B8_LO, 2);
    check("coef ascend", COEF_B8, {host_u.wbuf[1], 8'h5A});
    wr1(ADDR_INTERFACE_CONFIG_A, 8'h10);
    host_u.wbuf[0] = 8'hC3;
    host_u.wbuf[1] = next_rand();
    host_u.xfer(1'b0, ADDR_COEF_B8_HI, 2);
    check("coef descend", COEF_B8, {8'hC3, host_u.wbuf[1]});
    v = host_u.wbuf[1];
    host_u.xfer(1'b1, ADDR_COEF_B8_HI, 2);
    check("coef read descend", {host_u.rbuf[0], host_u.rbuf[1]}, {8'hC3, v});
    wr1(ADDR_USER_CONFIG, 8'h01);
    host_u.wbuf[0] = 8'h11;
    host_u.wbuf[1] = 8'h22;
    host_u.xfer(1'b0, ADDR_COEF_B8_LO, 2);
    check("coef hold", COEF_B8, 16'hC322);
    wr1(ADDR_USER_CONFIG, 8'h00);
    $display("test streaming done");
    wr1(15'h0005, 8'hA5);
    rd1(15'h0005, x);
    check("unmapped", x, {8'h00, UNMAPPED_READ});
    $display("test unmapped done");
    wr1(ADDR_POWER_STATE_CONFIG, 8'h03);
    hi_cnt = 0;
    wr1(ADDR_INTERFACE_CONFIG_A, 8'h80);
    check("reset length", hi_cnt[15:0], HOLD[15:0]);
    check("reset released", {15'h0000, CHIP_RESET}, 16'h0000);
    check("power after reset", POWER_MODE, 16'h0000);
    check("coef after reset", COEF_B8, COEF_B8_RST);
    rd1(ADDR_INTERFACE_CONFIG_A, x);
    check("config after reset", x, 16'h0030);
    $display("test soft reset done");
    complete_run();
  end
endmodule : interface_config_regs_tb_top

// *** test/spi_host_model.sv ***
// serial host model: drives frames on the serial port and samples read data
`timescale 1ns/10ps
module spi_host_model
  import cfg_regs_pkg::*;
(
  // clock
  input wire logic clk,
  // serial pins
  output logic sclk,
  output logic scs_n,
  output logic sdi,
  input wire logic sdo
);
  logic [7:0] wbuf [0:7];
  logic [7:0] rbuf [0:7];

  initial begin
    sclk = 1'b0;
    scs_n = 1'b1;
    sdi = 1'b0;
  end

  // ****************************************
  // bit and frame tasks
  // ****************************************
  task automatic shift_byte(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      @(posedge clk);
      sclk <= 1'b0;
      sdi <= tx[i];
      repeat (4) @(posedge clk);
      rx[i] = sdo;
      sclk <= 1'b1;
      repeat (3) @(posedge clk);
    end
  endtask : shift_byte

  task automatic xfer(input logic rd, input logic [14:0] addr, input int n);
    logic [7:0] junk;
    @(posedge clk);
    scs_n <= 1'b0;
    shift_byte({rd, addr[14:8]}, junk);
    shift_byte(addr[7:0], junk);
    for (int k = 0; k < n; k++) begin
      shift_byte(wbuf[k], rbuf[k]);
    end
    @(posedge clk);
    sclk <= 1'b0;
    repeat (4) @(posedge clk);
    scs_n <= 1'b1;
    // released data line must not keep its last value
    sdi <= ~sdi;
    repeat (4) @(posedge clk);
    if (!rd && addr == ADDR_INTERFACE_CONFIG_A && wbuf[0][SOFT_RESET_BIT]) begin
      repeat (SOFT_RESET_CYCLES) @(posedge clk);
    end
  endtask : xfer
endmodule : spi_host_model
